// [hw/rra_pkg.sv]
// Constants and types shared by the row repair analysis block.
package rra_pkg;
	// ****************************************
	// Memory geometry
	// ****************************************
	localparam int unsigned ADDR_W      = 7;
	localparam int unsigned SEL_BITS    = 1;
	localparam int unsigned NUM_REGIONS = 2;
	localparam int unsigned SPARES      = 2;
	localparam int unsigned CAP_W       = 4;
	localparam int unsigned NUM_SPARE   = NUM_REGIONS * SPARES;
	localparam int unsigned OUT_W       = 2;

	// ****************************************
	// Region select map and bounds
	// ****************************************
	localparam int unsigned SEL_POS [SEL_BITS] = '{6};
	localparam logic [SEL_BITS-1:0] REG_LO [NUM_REGIONS] = '{1'b0, 1'b1};
	localparam logic [SEL_BITS-1:0] REG_HI [NUM_REGIONS] = '{1'b0, 1'b1};

	// ****************************************
	// Capture group sources
	// ****************************************
	typedef enum logic [1:0] {
		RRA_SRC_ADDR = 2'b00,
		RRA_SRC_ONE  = 2'b01,
		RRA_SRC_ZERO = 2'b10
	} rra_src_t;
	localparam rra_src_t CAP_KIND [CAP_W] = '{RRA_SRC_ADDR, RRA_SRC_ADDR,
		RRA_SRC_ADDR, RRA_SRC_ADDR};
	localparam int unsigned CAP_POS [CAP_W] = '{2, 3, 4, 5};

	// ****************************************
	// Repair outcome encodings
	// ****************************************
	localparam logic [OUT_W-1:0] OUT_NONE   = 2'h0;
	localparam logic [OUT_W-1:0] OUT_REPAIR = 2'h1;
	localparam logic [OUT_W-1:0] OUT_FAIL   = 2'h2;
	localparam logic [OUT_W-1:0] OUT_RESET  = 2'h0;
	localparam int unsigned OUT_FAIL_BIT = 1;
endpackage

// [hw/rra_spare.sv]
// One spare row element: used flag and capture group.
`timescale 1ns/100ps
module rra_spare (
	input  wire logic                      i_mclk,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_clear,
	input  wire logic                      i_take,
	input  wire logic [rra_pkg::CAP_W-1:0] i_cap,
	output logic                           o_used,
	output logic [rra_pkg::CAP_W-1:0]      o_cap
);
	import rra_pkg::*;

	typedef struct packed {
		logic             used;
		logic [CAP_W-1:0] cap;
	} rra_spare_st_t;

	rra_spare_st_t st_q;
	rra_spare_st_t st_d;

	always_comb begin
		st_d = st_q;
		if (i_clear) begin
			st_d = '0;
		end else if (i_take) begin
			st_d.used = 1'b1;
			st_d.cap  = i_cap;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_used = st_q.used;
	assign o_cap  = st_q.cap;

	AST_TAKE_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_take && !i_clear) |=> (o_used && o_cap == $past(i_cap)))
		else $error("spare did not capture on allocation");
endmodule

// [hw/rra_top.sv]
// Row repair analysis: region match, spare allocation and outcome.
// Overview of operation
// - Record failing rows so accesses can be steered to spares.
// - Select bits indexed 0 to n-1, each one row address bit.
// - Allocate from a region only when select bits fall within its bounds.
// - With one region and no select bits, it covers all addresses.
// - Several regions need select bits; bounds cover the whole space.
// - Every region gets the same spare count, SPARES, set to two.
// - Capture bits record their assigned address bit of the failing row.
// - Capture bits may hold constant one or constant zero instead.
// - Each capture group has at least one bit, each a single bit.
// - One capture group per spare; example captures address bits 5 to 2.
// - Example select bit 0 is address bit 6; 0 low, 1 high bank.
// - Bank spares only repair failures within that same bank.
// - Each memory holds one outcome register and capture registers.
// - Registers live in controller or interface, by placement choice.
// - Outcome reports no repair, repair needed, or not repairable.
// - Each spare has a used flag; 1 means capture holds defect.
// - Outcome register sits on the setup scan chain for shifting out.
// - Outcome, captures and used flags drive output ports continuously.
`timescale 1ns/100ps
module rra_top (
	input  wire logic                                i_mclk,
	input  wire logic                                i_rst_n,
	input  wire logic                                i_start,
	input  wire logic                                i_fail,
	input  wire logic [rra_pkg::ADDR_W-1:0]          i_addr,
	input  wire logic                                i_scan_en,
	input  wire logic                                i_scan_in,
	output logic                                     o_scan_out,
	output logic [rra_pkg::OUT_W-1:0]                o_repair_outcome,
	output logic [rra_pkg::NUM_SPARE-1:0]            o_spare_used_flag,
	output logic [rra_pkg::NUM_SPARE*rra_pkg::CAP_W-1:0] o_capture_group
);
	import rra_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [OUT_W-1:0] outcome;
		logic             scan_out;
	} rra_st_t;

	rra_st_t st_q;
	rra_st_t st_d;

	logic [SEL_BITS-1:0]      sel;
	logic [CAP_W-1:0]         cap_val;
	logic [NUM_REGIONS-1:0]   in_region;
	logic [NUM_SPARE-1:0]     used;
	logic [NUM_SPARE*CAP_W-1:0] caps;
	logic [NUM_SPARE-1:0]     take;
	logic                     hit;
	logic                     full;

	// ****************************************
	// Region select and capture value
	// ****************************************
	always_comb begin
		for (int i = 0; i < SEL_BITS; i++) begin
			sel[i] = i_addr[SEL_POS[i]];
		end
		for (int b = 0; b < CAP_W; b++) begin
			case (CAP_KIND[b])
				RRA_SRC_ADDR: cap_val[b] = i_addr[CAP_POS[b]];
				RRA_SRC_ONE:  cap_val[b] = 1'b1;
				RRA_SRC_ZERO: cap_val[b] = 1'b0;
				default:      cap_val[b] = 1'b0;
			endcase
		end
		for (int r = 0; r < NUM_REGIONS; r++) begin
			in_region[r] = (NUM_REGIONS == 1) ||
				((sel >= REG_LO[r]) && (sel <= REG_HI[r]));
		end
	end

	// ****************************************
	// Spare allocation
	// ****************************************
	always_comb begin
		logic found;
		logic done;
		found = 1'b0;
		done  = 1'b0;
		hit  = 1'b0;
		full = 1'b0;
		take = '0;
		for (int r = 0; r < NUM_REGIONS; r++) begin
			for (int s = 0; s < SPARES; s++) begin
				if (in_region[r] && used[r*SPARES+s] &&
				    caps[(r*SPARES+s)*CAP_W +: CAP_W] == cap_val) begin
					hit = 1'b1;
				end
			end
		end
		for (int r = 0; r < NUM_REGIONS; r++) begin
			if (in_region[r] && !found) begin
				found = 1'b1;
				done  = 1'b0;
				for (int s = 0; s < SPARES; s++) begin
					if (!used[r*SPARES+s] && !done) begin
						done = 1'b1;
						take[r*SPARES+s] = i_fail && !hit && !i_start;
					end
				end
				full = !done;
			end
		end
	end

	for (genvar g = 0; g < NUM_SPARE; g++) begin : g_spare
		rra_spare u_spare (
			.i_mclk  (i_mclk),
			.i_rst_n (i_rst_n),
			.i_clear (i_start),
			.i_take  (take[g]),
			.i_cap   (cap_val),
			.o_used  (used[g]),
			.o_cap   (caps[g*CAP_W +: CAP_W])
		);
	end

	// ****************************************
	// Outcome register and setup scan
	// ****************************************
	always_comb begin
		st_d = st_q;
		if (i_start) begin
			st_d.outcome = OUT_NONE;
		end else if (i_scan_en) begin
			st_d.scan_out = st_q.outcome[0];
			st_d.outcome  = {i_scan_in, st_q.outcome[OUT_W-1]};
		end else if (i_fail && !hit &&
		             !st_q.outcome[OUT_FAIL_BIT]) begin
			if (full) begin
				st_d.outcome = OUT_FAIL;
			end else begin
				st_d.outcome = OUT_REPAIR;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			st_q <= '{outcome: OUT_RESET, scan_out: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign o_repair_outcome  = st_q.outcome;
	assign o_scan_out        = st_q.scan_out;
	assign o_spare_used_flag = used;
	assign o_capture_group   = caps;

	// ****************************************
	// Checks
	// ****************************************
	AST_FULL_FAIL: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_fail && !hit && full && !i_start && !i_scan_en) |=>
		o_repair_outcome[OUT_FAIL_BIT])
		else $error("exhausted region not flagged unrepairable");
	AST_NO_DOUBLE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_fail && hit && !i_start) |=> $stable(o_spare_used_flag))
		else $error("recorded row took another spare");
	AST_BANK_ONLY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_fail && !i_start && i_addr[SEL_POS[0]] == 1'b0) |=>
		o_spare_used_flag[3:2] == $past(o_spare_used_flag[3:2]))
		else $error("low bank failure used high bank spare");
	AST_REPAIR: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_fail && !hit && !full && !i_start && !i_scan_en &&
		 o_repair_outcome == OUT_NONE) |=> o_repair_outcome == OUT_REPAIR)
		else $error("first repairable failure not reported");
	AST_START_CLR: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		i_start |=> (o_repair_outcome == OUT_NONE && o_spare_used_flag == '0))
		else $error("start did not clear analysis");
	AST_SCAN: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_scan_en && !i_start) |=>
		o_scan_out == $past(o_repair_outcome[0]))
		else $error("scan out not shifted from outcome");
	AST_CAPTURE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(take[0]) |=> o_capture_group[CAP_W-1:0] == $past(i_addr[5:2]))
		else $error("capture group missed address bits");
	AST_USED_STICK: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(o_spare_used_flag[1] && !i_start) |=> o_spare_used_flag[1])
		else $error("used flag dropped without start");
endmodule

// [test/rra_mem_model.sv]
// Memory and self-test side model that presents failing row accesses.
`timescale 1ns/100ps
module rra_mem_model (
	input  wire logic                      i_mclk,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_req,
	input  wire logic [rra_pkg::ADDR_W-1:0] i_req_addr,
	output logic                           o_fail,
	output logic [rra_pkg::ADDR_W-1:0]      o_addr
);
	import rra_pkg::*;

	// failing row report
	// An idle address bus toggles so stale values are never trusted.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_fail <= 1'b0;
			o_addr <= '0;
		end else if (i_req) begin
			o_fail <= 1'b1;
			o_addr <= i_req_addr;
		end else begin
			o_fail <= 1'b0;
			o_addr <= ~o_addr;
		end
	end
endmodule

// [test/rra_top_tb_top.sv]
// Self-checking testbench for the row repair analysis block.
`timescale 1ns/100ps
module rra_top_tb_top;
	import rra_pkg::*;
	logic                       i_mclk    = 1'b0;
	logic                       i_rst_n   = 1'b0;
	logic                       i_start   = 1'b0;
	logic                       req       = 1'b0;
	logic                       i_scan_en = 1'b0;
	logic                       i_scan_in = 1'b0;
	logic [ADDR_W-1:0]          req_addr  = '0;
	logic [ADDR_W-1:0]          mem_addr;
	logic                       mem_fail;
	logic                       scan_out;
	logic [OUT_W-1:0]           outcome;
	logic [NUM_SPARE-1:0]       used;
	logic [NUM_SPARE*CAP_W-1:0] cap;
	int                         failures  = 0;
	int                         tests_run = 0;

	always #25 i_mclk = ~i_mclk;

	rra_mem_model u_mem (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(req),
		.i_req_addr(req_addr), .o_fail(mem_fail), .o_addr(mem_addr));

	rra_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_start(i_start),
		.i_fail(mem_fail), .i_addr(mem_addr), .i_scan_en(i_scan_en),
		.i_scan_in(i_scan_in), .o_scan_out(scan_out),
		.o_repair_outcome(outcome), .o_spare_used_flag(used),
		.o_capture_group(cap));

	// ****************************************
	// Checking and drivers
	// ****************************************
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic expect_state(logic [1:0] o, logic [3:0] u, logic [15:0] c);
		check("outcome", {14'h0, outcome}, {14'h0, o});
		check("used", {12'h0, used}, {12'h0, u});
		check("capture", cap, c);
	endtask

	task automatic fail_req(logic [ADDR_W-1:0] a);
		@(posedge i_mclk);
		req <= 1'b1;
		req_addr <= a;
	endtask

	task automatic settle();
		@(posedge i_mclk);
		req <= 1'b0;
		repeat (2) @(posedge i_mclk);
		#1;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_single();
		fail_req(7'h04);
		settle();
		expect_state(OUT_REPAIR, 4'b0001, 16'h0001);
	endtask

	task automatic t_bank_sep();
		fail_req(7'h04);
		fail_req(7'h7c);
		settle();
		expect_state(OUT_REPAIR, 4'b0101, 16'h0f01);
	endtask

	task automatic t_exhaust();
		fail_req(7'h08);
		fail_req(7'h0c);
		settle();
		expect_state(OUT_FAIL, 4'b0111, 16'h0f21);
	endtask

	task automatic t_scan();
		@(posedge i_mclk);
		i_scan_en <= 1'b1;
		i_scan_in <= 1'b1;
		@(posedge i_mclk);
		i_scan_in <= 1'b0;
		#1;
		check("shift1 out", {15'h0, scan_out}, 16'h0000);
		check("shift1 outcome", {14'h0, outcome}, 16'h0003);
		@(posedge i_mclk);
		i_scan_en <= 1'b0;
		#1;
		check("shift2 out", {15'h0, scan_out}, 16'h0001);
		check("shift2 outcome", {14'h0, outcome}, 16'h0001);
	endtask

	task automatic t_start();
		@(posedge i_mclk);
		i_start <= 1'b1;
		@(posedge i_mclk);
		i_start <= 1'b0;
		#1;
		expect_state(OUT_NONE, 4'b0000, 16'h0000);
	endtask

	task automatic give_verdict();
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge i_mclk);
		#1;
		expect_state(OUT_RESET, 4'b0000, 16'h0000);
		@(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_single();
		t_bank_sep();
		t_exhaust();
		t_scan();
		t_start();
		t_single();
		give_verdict();
	end
endmodule
